/* File: hw/afs_ctrl.sv */
// Temperature-driven fan duty controller with fault detection
`timescale 1ns/1ps
`default_nettype none
module afs_ctrl
  import afs_pkg::*;
#(
  parameter int EVAL_CNT  = EVAL_CYCLES,
  parameter int FAULT_CNT = FAULT_EVALS
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  mode,
  input  wire logic [7:0]  manual_duty,
  input  wire logic [63:0] temp_source_list,
  input  wire logic [11:0] selected_temp_slots,
  input  wire logic [7:0]  bound_low,
  input  wire logic [7:0]  bound_high,
  input  wire logic [7:0]  duty_low,
  input  wire logic [7:0]  duty_mid,
  input  wire logic [7:0]  hyst,
  input  wire logic        multi_en,
  input  wire logic [2:0]  slope_temp_source,
  input  wire logic [1:0]  slope_up,
  input  wire logic [1:0]  slope_dn,
  input  wire logic [11:0] tach_count,
  input  wire logic [11:0] expect_count,
  input  wire logic        fault_clear,
  output var  logic        pwm_out,
  output var  logic [7:0]  duty,
  output var  logic [7:0]  ctrl_temp,
  output var  logic        fan_fault_n
);
  typedef enum logic [2:0] {
    AFS_LOW  = 3'h1,
    AFS_MID  = 3'h2,
    AFS_HIGH = 3'h4
  } afs_band_e;

  typedef struct packed {
    logic [31:0] tick;
    logic [7:0]  duty;
    logic [7:0]  temp;
    afs_band_e   band;
    logic [7:0]  fault_cnt;
    logic        fault_n;
    logic [7:0]  slope_smp;
    logic        pwm;
  } afs_ctrl_s;

  afs_ctrl_s st;
  afs_ctrl_s next_st;

  logic [7:0]  src   [NUM_SRC];
  logic [7:0]  tmax;
  logic        pwm_raw;
  logic        eval;
  logic [7:0]  lin_duty;
  logic [15:0] prod;
  logic [7:0]  span_t;
  logic [7:0]  span_d;
  logic [7:0]  off_t;
  logic [7:0]  slope_add;
  logic [8:0]  lin_sum;
  logic        cond_full;
  logic        cond_stall;
  logic        recovered;

  // Unpack sources; signed two's complement temperatures
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      src[i] = temp_source_list[i*8 +: 8];
    end
  end

  // Maximum over four selected slots
  always_comb begin
    tmax = src[selected_temp_slots[2:0]];
    for (int s = 1; s < NUM_SLOT; s++) begin
      if ($signed(src[selected_temp_slots[s*3 +: 3]]) > $signed(tmax)) begin
        tmax = src[selected_temp_slots[s*3 +: 3]];
      end
    end
  end

  function automatic logic [7:0] afs_scale(input logic [7:0] v, input logic [1:0] k);
    case (k)
      SLOPE_ONE:     afs_scale = v;
      SLOPE_HALF:    afs_scale = {1'b0, v[7:1]};
      SLOPE_QUARTER: afs_scale = {2'b00, v[7:2]};
      default:       afs_scale = 8'h00;
    endcase
  endfunction : afs_scale

  // Linear interpolation between bound_low and bound_high
  always_comb begin
    span_t    = bound_high - bound_low;
    span_d    = duty_mid - duty_low;
    off_t     = st.temp - bound_low;
    prod      = 16'(off_t) * 16'(span_d);
    slope_add = 8'h00;
    if ($signed(st.slope_smp) > $signed(bound_high)) begin
      slope_add = afs_scale(8'(st.slope_smp - bound_high), slope_up);
    end else if ($signed(st.slope_smp) > $signed(bound_low)) begin
      slope_add = afs_scale(8'(st.slope_smp - bound_low), slope_dn);
    end
    // Clamp outside the boundaries so the offset never wraps
    if ($signed(st.temp) <= $signed(bound_low)) begin
      lin_sum = {1'b0, duty_low};
    end else if (span_t == 8'h00 || $signed(st.temp) >= $signed(bound_high)) begin
      lin_sum = {1'b0, duty_mid};
    end else begin
      lin_sum = 9'(duty_low) + 9'(prod / 16'(span_t));
    end
    if (multi_en) begin
      lin_sum = lin_sum + 9'(slope_add);
    end
    lin_duty = lin_sum[8] ? DUTY_FULL : lin_sum[7:0];
  end

  assign eval = (st.tick == 32'(EVAL_CNT - 1));

  always_comb begin
    next_st      = st;
    cond_full    = (st.duty == DUTY_FULL) && (tach_count > expect_count);
    cond_stall   = (st.duty > duty_low) && (tach_count == TACH_STALL);
    recovered    = (tach_count <= expect_count) && (tach_count != TACH_STALL);
    next_st.tick = eval ? 32'h0 : st.tick + 32'h1;
    next_st.pwm  = pwm_raw;
    if (mode == MODE_MANUAL) begin
      next_st.duty = manual_duty;
    end
    if (eval) begin
      next_st.temp = tmax;
      next_st.slope_smp = src[slope_temp_source];
      if (mode != MODE_MANUAL) begin
        // Band with hysteresis on the way down
        case (st.band)
          AFS_LOW: begin
            if ($signed(tmax) > $signed(bound_high)) begin
              next_st.band = AFS_HIGH;
            end else if ($signed(tmax) > $signed(bound_low)) begin
              next_st.band = AFS_MID;
            end
          end
          AFS_MID: begin
            if ($signed(tmax) > $signed(bound_high)) begin
              next_st.band = AFS_HIGH;
            end else if ($signed(tmax) < $signed(bound_low - hyst)) begin
              next_st.band = AFS_LOW;
            end
          end
          AFS_HIGH: begin
            if ($signed(tmax) < $signed(bound_high - hyst)) begin
              next_st.band = ($signed(tmax) > $signed(bound_low)) ? AFS_MID : AFS_LOW;
            end
          end
          default: next_st.band = AFS_LOW;
        endcase
      end
      if (cond_full || cond_stall) begin
        next_st.fault_cnt = (st.fault_cnt == 8'(FAULT_CNT)) ? st.fault_cnt
                                                          : st.fault_cnt + 8'h01;
      end else begin
        next_st.fault_cnt = 8'h00;
      end
    end
    if (st.fault_cnt == 8'(FAULT_CNT)) begin
      next_st.fault_n = 1'b0;
    end else if (fault_clear || recovered) begin
      next_st.fault_n = 1'b1;
    end
    if (fault_clear) begin
      next_st.fault_cnt = 8'h00;
    end
    // Duty from band, applied on the following cycle of the new band
    if (mode == MODE_STAGE) begin
      case (st.band)
        AFS_LOW:  next_st.duty = duty_low;
        AFS_MID:  next_st.duty = duty_mid;
        AFS_HIGH: next_st.duty = DUTY_FULL;
        default:  next_st.duty = DUTY_FULL;
      endcase
    end else if (mode == MODE_LINEAR) begin
      case (st.band)
        AFS_LOW:  next_st.duty = multi_en ? lin_duty : duty_low;
        AFS_MID:  next_st.duty = lin_duty;
        AFS_HIGH: next_st.duty = DUTY_FULL;
        default:  next_st.duty = DUTY_FULL;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st.tick      <= 32'h0;
      st.duty      <= DUTY_RESET;
      st.temp      <= 8'h00;
      st.band      <= AFS_LOW;
      st.fault_cnt <= 8'h00;
      st.fault_n   <= 1'b1;
      st.slope_smp <= 8'h00;
      st.pwm       <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  afs_pwm u_pwm (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .duty    (st.duty),
    .pwm_out (pwm_raw)
  );

  assign pwm_out     = st.pwm;
  assign duty        = st.duty;
  assign ctrl_temp   = st.temp;
  assign fan_fault_n = st.fault_n;

  a_manual_duty: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == MODE_MANUAL) [*2] |-> duty == $past(manual_duty))
    else $error("manual duty not followed");
  a_stage_top: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == MODE_STAGE && st.band == AFS_HIGH) |=> duty == DUTY_FULL)
    else $error("stage top band not full");
  a_stage_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode == MODE_STAGE && st.band == AFS_LOW) |=> duty == $past(duty_low))
    else $error("stage low band duty wrong");
  a_band_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    !eval |=> $stable(st.band))
    else $error("band changed outside tick");
  a_hyst_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (eval && st.band == AFS_HIGH && mode != MODE_MANUAL
     && $signed(tmax) >= $signed(bound_high - hyst)) |=> st.band == AFS_HIGH)
    else $error("full duty left inside hysteresis");
  a_lin_full: assert property (@(posedge sys_clk) disable iff (!rstn)
    (eval && mode == MODE_LINEAR && $signed(tmax) > $signed(bound_high))
    |=> st.band == AFS_HIGH ##1 (mode != MODE_LINEAR || duty == DUTY_FULL))
    else $error("linear did not go full");
  a_fault_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    (st.fault_cnt == 8'(FAULT_CNT)) |=> !fan_fault_n)
    else $error("fault not raised after timeout");
  a_fault_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!fan_fault_n && !fault_clear && !recovered) |=> !fan_fault_n)
    else $error("fault dropped without cause");
  a_tick_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
    st.tick < 32'(EVAL_CNT))
    else $error("tick counter overran");
endmodule : afs_ctrl
`default_nettype wire

/* File: hw/afs_pkg.sv */
// Package for the automatic fan speed control block
package afs_pkg;
  localparam int          CLK_MHZ       = 200;
  localparam int          EVAL_PERIOD_MS = 1000;
  localparam int          EVAL_CYCLES   = EVAL_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int          FAULT_SEC     = 11;
  localparam int          FAULT_EVALS   = FAULT_SEC * 1000 / EVAL_PERIOD_MS;
  localparam logic [7:0]  DUTY_RESET    = 8'hFF;
  localparam logic [7:0]  DUTY_FULL     = 8'hFF;
  localparam logic [7:0]  PWM_TOP       = 8'hFE;
  localparam logic [7:0]  HYST_RESET    = 8'h04;
  localparam logic [11:0] TACH_STALL    = 12'hFFF;
  localparam int          NUM_SRC       = 8;
  localparam int          NUM_SLOT      = 4;
  localparam logic [1:0]  MODE_MANUAL   = 2'h0;
  localparam logic [1:0]  MODE_STAGE    = 2'h1;
  localparam logic [1:0]  MODE_LINEAR   = 2'h2;
  localparam logic [1:0]  SLOPE_ONE     = 2'h0;
  localparam logic [1:0]  SLOPE_HALF    = 2'h1;
  localparam logic [1:0]  SLOPE_QUARTER = 2'h2;
  localparam logic [1:0]  SLOPE_ZERO    = 2'h3;
endpackage : afs_pkg

/* File: hw/afs_pwm.sv */
// PWM generator with duty over a 255-step period
`timescale 1ns/1ps
`default_nettype none
module afs_pwm
  import afs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] duty,
  output var  logic       pwm_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } afs_pwm_s;

  afs_pwm_s st;
  afs_pwm_s next_st;

  // High for duty counts out of 255
  always_comb begin
    next_st     = st;
    next_st.cnt = (st.cnt == PWM_TOP) ? 8'h00 : st.cnt + 8'h01;
    next_st.out = (st.cnt < duty);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pwm_out = st.out;

  a_pwm_full_high: assert property (@(posedge sys_clk) disable iff (!rstn)
    (duty == DUTY_FULL) [*2] |=> pwm_out)
    else $error("pwm low at full duty");
endmodule : afs_pwm
`default_nettype wire

/* File: test/afs_fan_model.sv */
// Fan model: tach count by speed setting, PWM high-cycle meter
`timescale 1ns/1ps
`default_nettype none
module afs_fan_model (
  input  wire logic        sys_clk,
  input  wire logic        pwm_out,
  input  wire logic [1:0]  speed,
  output var  logic [11:0] tach_count,
  output var  logic [7:0]  hi_cnt
);
  logic [7:0] pos  = 8'h00;
  logic [7:0] acc  = 8'h00;
  logic [7:0] last = 8'h00;
  assign hi_cnt = last;
  // Stopped reads all ones, slow above expected, fast below
  assign tach_count = (speed == 2'h0) ? 12'hFFF : (speed == 2'h1) ? 12'h900 : 12'h100;
  // High cycles over each 255-cycle window
  always @(posedge sys_clk) begin
    pos <= (pos == 8'hFE) ? 8'h00 : pos + 8'h01;
    acc <= (pos == 8'hFE) ? 8'h00 : acc + 8'(pwm_out);
    if (pos == 8'hFE)
      last <= acc + 8'(pwm_out);
  end
endmodule : afs_fan_model
`default_nettype wire

/* File: test/tb_top.sv */
// Testbench for the fan duty controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import afs_pkg::*;
  localparam int EV = 20;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  mode = MODE_MANUAL;
  logic [7:0]  manual_duty = 8'hFF;
  logic [63:0] temps = '0;
  logic [11:0] slots = {3'd5, 3'd2, 3'd1, 3'd0};
  logic [7:0]  duty_low = 8'h80;
  logic [7:0]  duty_mid = 8'hB3;
  logic        fault_clear = 1'b0;
  logic        multi_en = 1'b0;
  logic [1:0]  slope_up = SLOPE_ONE;
  logic [1:0]  slope_dn = SLOPE_ONE;
  logic [1:0]  speed = 2'h2;
  logic [11:0] tach_count;
  logic [7:0]  hi_cnt;
  logic        pwm_out;
  logic [7:0]  duty;
  logic [7:0]  ctrl_temp;
  logic        fan_fault_n;
  int          err_total = 0;
  int          n_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  afs_ctrl #(.EVAL_CNT(EV), .FAULT_CNT(3)) i_afs_ctrl (
    .sys_clk(sys_clk), .rstn(rstn), .mode(mode), .manual_duty(manual_duty),
    .temp_source_list(temps), .selected_temp_slots(slots), .bound_low(8'h28),
    .bound_high(8'h3C), .duty_low(duty_low), .duty_mid(duty_mid), .hyst(HYST_RESET),
    .multi_en(multi_en), .slope_temp_source(3'd0), .slope_up(slope_up), .slope_dn(slope_dn),
    .tach_count(tach_count), .expect_count(12'h400), .fault_clear(fault_clear),
    .pwm_out(pwm_out), .duty(duty), .ctrl_temp(ctrl_temp), .fan_fault_n(fan_fault_n));
  afs_fan_model i_afs_fan_model (
    .sys_clk(sys_clk), .pwm_out(pwm_out), .speed(speed), .tach_count(tach_count),
    .hi_cnt(hi_cnt));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s saw %h want %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic evals(input int n);
    repeat (n * EV + 4) @(negedge sys_clk);
  endtask : evals
  task automatic wait_fault(input logic lvl, input int n);
    int i;
    for (i = 0; i < n && fan_fault_n !== lvl; i++)
      @(negedge sys_clk);
    check(fan_fault_n, lvl, "fault level");
    if (fan_fault_n !== lvl)
      close_out();
  endtask : wait_fault
  // Hot value on source 5, cool elsewhere and negative on source 0
  task automatic step(input logic [7:0] hot, input logic [7:0] exp);
    temps = {8'h0A, 8'h0A, hot, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'hD8};
    evals(2);
    check(ctrl_temp, hot, "max temp");
    check(duty, exp, "auto duty");
  endtask : step
  task automatic test_manual();
    mode = MODE_MANUAL;
    manual_duty = 8'h40;
    repeat (3) @(negedge sys_clk);
    check(duty, 8'h40, "manual duty");
    repeat (520) @(negedge sys_clk);
    check(hi_cnt, 8'h40, "pwm high");
    $display("test manual done");
  endtask : test_manual
  task automatic test_stage();
    mode = MODE_STAGE;
    step(8'h1E, 8'h80);
    step(8'h32, 8'hB3);
    step(8'h46, 8'hFF);
    step(8'h3A, 8'hFF);
    step(8'h32, 8'hB3);
    $display("test stage done");
  endtask : test_stage
  task automatic test_linear();
    mode = MODE_LINEAR;
    duty_low = 8'h40;
    duty_mid = 8'h94;
    step(8'h1E, 8'h40);
    step(8'h32, 8'h6A);
    step(8'h46, 8'hFF);
    step(8'h3A, 8'hFF);
    step(8'h32, 8'h6A);
    $display("test linear done");
  endtask : test_linear
  // Slope source on source 0, kept out of the maximum
  task automatic slope(input logic [7:0] src0, input logic [1:0] up, input logic [1:0] dn,
                       input logic [7:0] exp);
    slope_up = up;
    slope_dn = dn;
    temps = {8'h0A, 8'h0A, 8'h32, 8'h0A, 8'h0A, 8'h0A, 8'h0A, src0};
    evals(2);
    check(duty, exp, "slope duty");
  endtask : slope
  task automatic test_multi();
    slots = {3'd5, 3'd2, 3'd1, 3'd1};
    multi_en = 1'b1;
    slope(8'h30, SLOPE_ONE, SLOPE_HALF, 8'h6E);
    slope(8'h46, SLOPE_QUARTER, SLOPE_HALF, 8'h6C);
    slope(8'h46, SLOPE_ONE, SLOPE_HALF, 8'h74);
    slope(8'h46, SLOPE_ZERO, SLOPE_ONE, 8'h6A);
    multi_en = 1'b0;
    slots = {3'd5, 3'd2, 3'd1, 3'd0};
    $display("test multi done");
  endtask : test_multi
  task automatic test_fault();
    mode = MODE_MANUAL;
    manual_duty = 8'hFF;
    speed = 2'h1;
    evals(1);
    check(fan_fault_n, 1'b1, "fault early");
    wait_fault(1'b0, 8 * EV);
    speed = 2'h2;
    wait_fault(1'b1, 4 * EV);
    manual_duty = 8'h80;
    speed = 2'h0;
    wait_fault(1'b0, 8 * EV);
    speed = 2'h1;
    evals(1);
    check(fan_fault_n, 1'b0, "fault held");
    fault_clear = 1'b1;
    wait_fault(1'b1, 4 * EV);
    fault_clear = 1'b0;
    $display("test fault done");
  endtask : test_fault
  initial begin
    repeat (4) @(negedge sys_clk);
    check(duty, DUTY_RESET, "reset duty");
    check(fan_fault_n, 1'b1, "reset fault");
    rstn = 1'b1;
    @(negedge sys_clk);
    test_manual();
    test_stage();
    test_linear();
    test_multi();
    test_fault();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
